// ==== lan_flow_control_wake_status.sv ====
/*
  flow-control status and wake-event status registers of a lan controller.
  assumes mac, receive fifo and filter logic on i_clk give one-cycle event
  pulses; link status arrives from a pin and is synchronised here.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - low pause set nonzero; cleared zero/pause
// - pause active on any pause cause but a low pause frame
// - pause sent set on nonzero transmit
// - pause request acts like full fifo
// - descriptor pause flag sets pause request
// - only resume bit clears pause request
// - resume bit reads as zero
// - threshold selects free fifo bytes
// - link change sticky until one written
// - wake pattern sets flag unconditionally
// - filtered packet sets wake flag
// - power event mirrors wake status
// - clearing power event drops wake output
// - wake flags cleared only by writing one
module lan_flow_control_wake_status
  import lan_fc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [9:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [10:0] i_fifo_free,
  input wire logic i_rx_pause,
  input wire logic i_rx_pause_low,
  input wire logic [15:0] i_rx_pause_val,
  input wire logic i_desc_pause,
  input wire logic i_tx_pause_done,
  input wire logic [15:0] i_pause_time,
  input wire logic i_link_up,
  input wire logic i_wake_pattern,
  input wire logic i_filter_match,
  input wire logic i_wake_event,
  output logic o_pause_gen,
  output logic [15:0] o_pause_val,
  output logic o_pause_active,
  output logic o_power_wake_event,
  output logic o_power_mgmt_ctrl_stat
);
  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic wr_fc;
  logic wr_ws;
  logic rd_fc;
  logic rd_ws;
  assign wr_fc = i_wr && (i_addr == FLOW_CTRL_ADDR);
  assign wr_ws = i_wr && (i_addr == WAKE_STAT_ADDR);
  assign rd_fc = i_rd && (i_addr == FLOW_CTRL_ADDR);
  assign rd_ws = i_rd && (i_addr == WAKE_STAT_ADDR);

  // ---------------------------------------------------------------
  // link status synchroniser
  // ---------------------------------------------------------------
  logic link_s1_ff;
  logic link_s2_ff;
  logic link_s3_ff;
  logic link_prime_ff;
  logic link_chg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_s3_ff <= 1'b0;
      link_prime_ff <= 1'b0;
    end else begin
      link_s1_ff <= i_link_up;
      link_s2_ff <= link_s1_ff;
      link_s3_ff <= link_s2_ff;
      link_prime_ff <= 1'b1;
    end
  end
  // first cycle after reset is ignored; a link already up at reset still shows as a change
  assign link_chg = link_prime_ff && (link_s2_ff != link_s3_ff);

  // ---------------------------------------------------------------
  // threshold and pause request
  // ---------------------------------------------------------------
  logic [2:0] thresh_ff;
  logic [2:0] nxt_thresh;
  logic req_ff;
  logic nxt_req;
  logic fifo_hit;
  logic req_set;
  logic req_clr;
  assign nxt_thresh = wr_fc ? i_wdata[THRESH_LSB +: THRESH_W] : thresh_ff;
  assign fifo_hit = ({2'b00, i_fifo_free} <= thresh_bytes(thresh_ff));
  assign req_set = (wr_fc && i_wdata[PAUSE_REQ_BIT]) || i_desc_pause;
  assign req_clr = wr_fc && i_wdata[RESUME_REQ_BIT];
  assign nxt_req = req_set | (req_ff & ~req_clr);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      thresh_ff <= THRESH_RST;
      req_ff <= 1'b0;
    end else begin
      thresh_ff <= nxt_thresh;
      req_ff <= nxt_req;
    end
  end

  // ---------------------------------------------------------------
  // pause frame generation
  // ---------------------------------------------------------------
  logic cause;
  logic gen_ff;
  logic nxt_gen;
  logic t_run;
  logic [15:0] pval_ff;
  assign cause = fifo_hit || req_ff;
  // one frame per pause period; a held cause re-sends only after the timer runs out
  assign nxt_gen = cause && !t_run && !i_tx_pause_done;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gen_ff <= 1'b0;
      pval_ff <= 16'h0000;
    end else begin
      gen_ff <= nxt_gen;
      pval_ff <= i_pause_time;
    end
  end
  assign o_pause_gen = gen_ff;
  assign o_pause_val = pval_ff;

  // ---------------------------------------------------------------
  // pause timer and status bits
  // ---------------------------------------------------------------
  logic rx_load;
  logic tx_load;
  logic t_load;
  logic [15:0] t_value;
  logic t_zero;
  assign rx_load = i_rx_pause || i_rx_pause_low;
  assign tx_load = i_tx_pause_done && (i_pause_time != 16'h0000);
  assign t_load = rx_load || tx_load;
  assign t_value = rx_load ? i_rx_pause_val : i_pause_time;
  pause_timer u_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_load(t_load),
    .i_value(t_value),
    .o_zero_pulse(t_zero),
    .o_running(t_run)
  );
  logic low_ff;
  logic act_ff;
  logic sent_ff;
  logic nxt_low;
  logic nxt_act;
  logic nxt_sent;
  logic low_set;
  logic act_set;
  logic sent_set;
  assign low_set = i_rx_pause_low && (i_rx_pause_val != 16'h0000);
  assign nxt_low = low_set | (low_ff & ~(t_zero | i_rx_pause));
  assign act_set = cause || i_desc_pause || i_rx_pause;
  assign nxt_act = act_set | (act_ff & ~t_zero);
  assign sent_set = tx_load;
  assign nxt_sent = sent_set | (sent_ff & ~t_zero);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_ff <= 1'b0;
      act_ff <= 1'b0;
      sent_ff <= 1'b0;
    end else begin
      low_ff <= nxt_low;
      act_ff <= nxt_act;
      sent_ff <= nxt_sent;
    end
  end
  assign o_pause_active = act_ff;

  // ---------------------------------------------------------------
  // wake event flags
  // ---------------------------------------------------------------
  logic [3:0] ws_set;
  logic [3:0] ws_clr;
  logic [3:0] ws_q;
  localparam int WS_POS [4] = '{LINK_CHG_BIT, WAKE_PAT_BIT, FILT_PKT_BIT, PWR_EVT_BIT};
  assign ws_set = {link_chg, i_wake_pattern, i_filter_match, i_wake_event};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ws
      assign ws_clr[gi] = wr_ws && i_wdata[WS_POS[3 - gi]];
      w1c_flag u_flag (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set(ws_set[gi]),
        .i_clr(ws_clr[gi]),
        .o_flag(ws_q[gi])
      );
    end
  endgenerate
  assign o_power_mgmt_ctrl_stat = ws_q[0];
  assign o_power_wake_event = ws_q[0];

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  logic [31:0] fc_word;
  logic [31:0] ws_word;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  assign fc_word = {19'h0_0000, low_ff, act_ff, sent_ff, req_ff, 1'b0, 5'h00, thresh_ff};
  assign ws_word = {24'h00_0000, ws_q[3], ws_q[2], ws_q[1], 4'h0, ws_q[0]};
  assign nxt_rdata = rd_fc ? fc_word : (rd_ws ? ws_word : 32'h0000_0000);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_req_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    (req_ff && !req_clr) |=> req_ff;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("pause request lost");
  property p_req_set;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_desc_pause |=> req_ff;
  endproperty
  a_req_set: assert property (p_req_set) else $error("descriptor pause missed");
  property p_req_gen;
    @(posedge i_clk) disable iff (!i_arst_n)
    (req_ff && !t_run && !i_tx_pause_done) |=> o_pause_gen;
  endproperty
  a_req_gen: assert property (p_req_gen) else $error("request did not pause");
  property p_low;
    @(posedge i_clk) disable iff (!i_arst_n)
    low_set |=> low_ff;
  endproperty
  a_low: assert property (p_low) else $error("low pause not set");
  property p_act_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
    (t_zero && !act_set) |=> !act_ff;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("pause active stuck");
  property p_sent;
    @(posedge i_clk) disable iff (!i_arst_n)
    tx_load |=> sent_ff;
  endproperty
  a_sent: assert property (p_sent) else $error("pause sent not set");
  property p_resume_rd;
    @(posedge i_clk) disable iff (!i_arst_n)
    rd_fc |=> !o_rdata[RESUME_REQ_BIT];
  endproperty
  a_resume_rd: assert property (p_resume_rd) else $error("resume bit read one");
  property p_link;
    @(posedge i_clk) disable iff (!i_arst_n)
    link_chg |=> ws_q[3];
  endproperty
  a_link: assert property (p_link) else $error("link change missed");
  property p_wake_pat;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_wake_pattern |=> ws_q[2];
  endproperty
  a_wake_pat: assert property (p_wake_pat) else $error("wake pattern missed");
  property p_filt;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_filter_match |=> ws_q[1];
  endproperty
  a_filt: assert property (p_filt) else $error("filter match missed");
  property p_pwr_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ws_clr[0] && !i_wake_event) |=> !o_power_wake_event && !o_power_mgmt_ctrl_stat;
  endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power event not cleared");
  property p_pwr_set;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_wake_event |=> o_power_mgmt_ctrl_stat;
  endproperty
  a_pwr_set: assert property (p_pwr_set) else $error("power event missed");
  property p_keep;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ws_q[1] && !ws_clr[1]) |=> ws_q[1];
  endproperty
  a_keep: assert property (p_keep) else $error("flag dropped without write");
  property p_tmr;
    @(posedge i_clk) disable iff (!i_arst_n)
    (tx_load && !rx_load && i_pause_time == 16'h0001) |-> ##[1:700] t_zero;
  endproperty
  a_tmr: assert property (p_tmr) else $error("pause timer did not expire");

  // ---------------------------------------------------------------
  // multi-step checks
  // ---------------------------------------------------------------
  sequence s_tx_pause;
    tx_load && !rx_load;
  endsequence
  sequence s_timer_armed;
    t_run && !o_pause_gen;
  endsequence
  sequence s_fifo_ready;
    fifo_hit && !t_run && !i_tx_pause_done;
  endsequence
  property p_tx_arm;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_tx_pause |=> s_timer_armed;
  endproperty
  a_tx_arm: assert property (p_tx_arm) else $error("sent pause did not arm timer");
  property p_fifo_gen;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_fifo_ready |=> o_pause_gen;
  endproperty
  a_fifo_gen: assert property (p_fifo_gen) else $error("threshold did not pause");
  property p_low_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
    ((t_zero || i_rx_pause) && !low_set) |=> !low_ff;
  endproperty
  a_low_clr: assert property (p_low_clr) else $error("low pause not cleared");
  property p_sent_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
    (t_zero && !sent_set) |=> !sent_ff;
  endproperty
  a_sent_clr: assert property (p_sent_clr) else $error("pause sent not cleared");
  property p_link_keep;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ws_q[3] && !ws_clr[3]) |=> ws_q[3];
  endproperty
  a_link_keep: assert property (p_link_keep) else $error("link flag dropped");
endmodule

// ==== lan_fc_pkg.sv ====
/*
  package for the flow-control and wake-status block: register indices,
  field positions, reset values and pause timing constants.
  assumes a 125 MHz core clock and a byte-wide index register port.
*/
package lan_fc_pkg;
  // ---------------------------------------------------------------
  // register map (indices, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] FLOW_CTRL_IDX = 8'h19;
  localparam logic [7:0] WAKE_STAT_IDX = 8'h1b;
  localparam logic [9:0] FLOW_CTRL_ADDR = {FLOW_CTRL_IDX, 2'b00};
  localparam logic [9:0] WAKE_STAT_ADDR = {WAKE_STAT_IDX, 2'b00};
  localparam logic [15:0] FLOW_CTRL_RST = 16'h0000;
  localparam logic [7:0] WAKE_STAT_RST = 8'h00;
  // ---------------------------------------------------------------
  // flow control fields
  // ---------------------------------------------------------------
  localparam int LOW_PAUSE_BIT = 12;
  localparam int PAUSE_ACT_BIT = 11;
  localparam int PAUSE_SENT_BIT = 10;
  localparam int PAUSE_REQ_BIT = 9;
  localparam int RESUME_REQ_BIT = 8;
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 3;
  localparam logic [2:0] THRESH_RST = 3'h0;
  // ---------------------------------------------------------------
  // wake status fields
  // ---------------------------------------------------------------
  localparam int LINK_CHG_BIT = 7;
  localparam int WAKE_PAT_BIT = 6;
  localparam int FILT_PKT_BIT = 5;
  localparam int PWR_EVT_BIT = 0;
  // ---------------------------------------------------------------
  // timing: one pause quantum is 512 bit times at 100 Mb/s
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int QUANTUM_NS = 5120;
  localparam int QUANTUM_CYC = (QUANTUM_NS * CLK_MHZ) / 1000;
  localparam int FREE_BYTES_UNIT = 512;
  localparam logic [10:0] FIFO_BYTES = 11'h7ff;
  // ---------------------------------------------------------------
  // free-byte threshold per encoding: (code + 1) * 0.50 KB
  // ---------------------------------------------------------------
  function automatic logic [12:0] thresh_bytes(input logic [2:0] code);
    thresh_bytes = 13'((int'(code) + 1) * FREE_BYTES_UNIT);
  endfunction
endpackage

// ==== pause_timer.sv ====
/*
  pause timer: loads a quantum count and steps it down once per quantum.
  assumes loads come from the same clock domain as single-cycle pulses.
*/
`timescale 1ns/10ps
module pause_timer
  import lan_fc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [15:0] i_value,
  output logic o_zero_pulse,
  output logic o_running
);
  // ---------------------------------------------------------------
  // quantum divider and count
  // ---------------------------------------------------------------
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [9:0] div_ff;
  logic [9:0] nxt_div;
  logic tick;
  assign tick = (div_ff == 10'(QUANTUM_CYC - 1));
  assign nxt_div = (i_load || tick) ? 10'h000 : div_ff + 10'h001;
  assign nxt_cnt = i_load ? i_value : ((tick && cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff);
  assign o_running = (cnt_ff != 16'h0000);
  assign o_zero_pulse = !i_load && tick && (cnt_ff == 16'h0001);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 16'h0000;
      div_ff <= 10'h000;
    end else begin
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
    end
  end
endmodule

// ==== w1c_flag.sv ====
/*
  sticky event flag cleared by writing one; a set in the clear cycle wins.
  assumes set and clear are same-domain single-cycle terms.
*/
`timescale 1ns/10ps
module w1c_flag (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);
  logic flag_ff;
  logic nxt_flag;
  assign nxt_flag = i_set | (flag_ff & ~i_clr);
  assign o_flag = flag_ff;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
endmodule

// ==== pause_partner_model.sv ====
/*
  far-side model: remote station and mac transmit path reporting pause frames.
  assumes the bench calls its tasks from the i_clk domain.
*/
`timescale 1ns/10ps
module pause_partner_model (
  input wire logic i_clk,
  input wire logic i_pause_gen,
  output logic o_rx_pause,
  output logic o_rx_pause_low,
  output logic [15:0] o_rx_pause_val,
  output logic o_tx_pause_done,
  output logic [15:0] o_pause_time,
  output logic o_link_up
);
  // raised by the bench for a slow answer
  int resp_dly = 4;
  int cnt = -1;
  logic gen_q = 1'b0;
  initial begin
    o_rx_pause = 1'b0;
    o_rx_pause_low = 1'b0;
    o_rx_pause_val = 16'h0000;
    o_tx_pause_done = 1'b0;
    o_pause_time = 16'h0001;
    o_link_up = 1'b0;
  end
  // ---------------------------------------------------------------
  // transmit path: one pause frame per rising request
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    gen_q <= i_pause_gen;
    o_tx_pause_done <= (cnt == 0);
    if (i_pause_gen && !gen_q) begin
      cnt <= resp_dly;
    end else if (cnt >= 0) begin
      cnt <= cnt - 1;
    end
  end
  task automatic send(input logic low, input logic [15:0] val);
    @(posedge i_clk);
    o_rx_pause <= !low;
    o_rx_pause_low <= low;
    o_rx_pause_val <= val;
    @(posedge i_clk);
    o_rx_pause <= 1'b0;
    o_rx_pause_low <= 1'b0;
    // value is stale once the pulse ends, so show its inverse
    o_rx_pause_val <= ~val;
  endtask
  task automatic toggle_link;
    @(posedge i_clk);
    o_link_up <= !o_link_up;
  endtask
endmodule

// ==== testbench.sv ====
/*
  self-checking bench for the flow-control and wake-status registers.
  assumes the partner model drives the pause and link inputs.
*/
`timescale 1ns/10ps
module testbench;
  import lan_fc_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [9:0] i_addr = 10'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [10:0] i_fifo_free = 11'h7ff;
  logic i_desc_pause = 1'b0;
  logic i_wake_pattern = 1'b0;
  logic i_filter_match = 1'b0;
  logic i_wake_event = 1'b0;
  logic [31:0] o_rdata;
  logic rx_pause, rx_pause_low, tx_done, link_up, o_pause_gen, o_pause_active;
  logic o_power_wake_event, o_power_mgmt_ctrl_stat;
  logic [15:0] rx_val, pause_time, o_pause_val;
  int fails = 0;
  int n_tests = 0;
  always #4 i_clk = ~i_clk;
  lan_flow_control_wake_status u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fifo_free(i_fifo_free),
    .i_rx_pause(rx_pause), .i_rx_pause_low(rx_pause_low), .i_rx_pause_val(rx_val),
    .i_desc_pause(i_desc_pause), .i_tx_pause_done(tx_done), .i_pause_time(pause_time),
    .i_link_up(link_up), .i_wake_pattern(i_wake_pattern), .i_filter_match(i_filter_match),
    .i_wake_event(i_wake_event), .o_pause_gen(o_pause_gen), .o_pause_val(o_pause_val),
    .o_pause_active(o_pause_active), .o_power_wake_event(o_power_wake_event),
    .o_power_mgmt_ctrl_stat(o_power_mgmt_ctrl_stat));
  pause_partner_model u_partner (.i_clk(i_clk), .i_pause_gen(o_pause_gen),
    .o_rx_pause(rx_pause), .o_rx_pause_low(rx_pause_low), .o_rx_pause_val(rx_val),
    .o_tx_pause_done(tx_done), .o_pause_time(pause_time), .o_link_up(link_up));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, e, o_rdata & m);
  endtask
  task automatic pulse(input int w);
    @(posedge i_clk);
    {i_desc_pause, i_wake_event, i_wake_pattern, i_filter_match} <= 4'(1 << w);
    @(posedge i_clk);
    {i_desc_pause, i_wake_event, i_wake_pattern, i_filter_match} <= 4'h0;
  endtask
  // bounded wait for the pause timer to run out
  task automatic wait_idle;
    for (int k = 0; k < 4 * QUANTUM_CYC && o_pause_active !== 1'b0; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk("pause_active idle", 32'h0000_0000, o_pause_active);
    if (o_pause_active !== 1'b0) begin
      end_sim();
    end
  endtask
  initial begin
    repeat (90000) @(posedge i_clk);
    fails++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int b;
    logic [31:0] m;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd_chk("flow reset", FLOW_CTRL_ADDR, 32'hffff_ffff, 32'(FLOW_CTRL_RST));
    rd_chk("wake reset", WAKE_STAT_ADDR, 32'hffff_ffff, 32'(WAKE_STAT_RST));
    rd_chk("unmapped read", 10'h3fc, 32'hffff_ffff, 32'h0000_0000);
    wr(FLOW_CTRL_ADDR, 32'h0000_0200);
    cyc(2);
    chk("pause_gen on request", 32'h0000_0001, o_pause_gen);
    rd_chk("request and active", FLOW_CTRL_ADDR, 32'h0000_0a00, 32'h0000_0a00);
    cyc(8);
    chk("pause_gen after frame", 32'h0000_0000, o_pause_gen);
    chk("pause value", 32'h0000_0001, o_pause_val);
    rd_chk("pause sent", FLOW_CTRL_ADDR, 32'h0000_0400, 32'h0000_0400);
    wr(FLOW_CTRL_ADDR, 32'h0000_0000);
    rd_chk("request kept", FLOW_CTRL_ADDR, 32'h0000_0200, 32'h0000_0200);
    wr(FLOW_CTRL_ADDR, 32'h0000_0100);
    rd_chk("request cleared", FLOW_CTRL_ADDR, 32'h0000_0300, 32'h0000_0000);
    wait_idle();
    rd_chk("status cleared", FLOW_CTRL_ADDR, 32'h0000_1c00, 32'h0000_0000);
    pulse(3);
    rd_chk("descriptor request", FLOW_CTRL_ADDR, 32'h0000_0a00, 32'h0000_0a00);
    wr(FLOW_CTRL_ADDR, 32'h0000_0100);
    wait_idle();
    u_partner.send(1'b1, 16'h0000);
    rd_chk("low pause zero", FLOW_CTRL_ADDR, 32'h0000_1000, 32'h0000_0000);
    u_partner.send(1'b1, 16'h0005);
    rd_chk("low pause set", FLOW_CTRL_ADDR, 32'h0000_1000, 32'h0000_1000);
    u_partner.send(1'b0, 16'h0001);
    rd_chk("low cleared by pause", FLOW_CTRL_ADDR, 32'h0000_1000, 32'h0000_0000);
    wait_idle();
    u_partner.send(1'b1, 16'h0001);
    cyc(QUANTUM_CYC - 20);
    rd_chk("low held", FLOW_CTRL_ADDR, 32'h0000_1000, 32'h0000_1000);
    cyc(30);
    rd_chk("low expired", FLOW_CTRL_ADDR, 32'h0000_1000, 32'h0000_0000);
    wait_idle();
    for (int c = 0; c < 3; c++) begin
      if (c == 2) begin
        u_partner.resp_dly = 30;
      end
      wr(FLOW_CTRL_ADDR, 32'(c));
      rd_chk("threshold field", FLOW_CTRL_ADDR, 32'h0000_0007, 32'(c));
      @(posedge i_clk);
      i_fifo_free <= 11'((c + 1) * 512 + 1);
      cyc(4);
      chk("no pause above threshold", 32'h0000_0000, o_pause_gen);
      @(posedge i_clk);
      i_fifo_free <= 11'((c + 1) * 512);
      cyc(4);
      chk("pause at threshold", 32'h0000_0001, o_pause_gen);
      @(posedge i_clk);
      i_fifo_free <= 11'h7ff;
      wait_idle();
    end
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 5 : (i == 1) ? 6 : 0;
      m = 32'(1 << b);
      pulse(i);
      rd_chk("wake flag set", WAKE_STAT_ADDR, m, m);
      wr(WAKE_STAT_ADDR, 32'h0000_0000);
      rd_chk("wake flag kept", WAKE_STAT_ADDR, m, m);
      if (i == 2) begin
        chk("wake output", 32'h0000_0001, o_power_wake_event);
        chk("pm status", 32'h0000_0001, o_power_mgmt_ctrl_stat);
      end
      wr(WAKE_STAT_ADDR, m);
      rd_chk("wake flag cleared", WAKE_STAT_ADDR, m, 32'h0000_0000);
    end
    chk("wake output cleared", 32'h0000_0000, o_power_wake_event);
    chk("pm status cleared", 32'h0000_0000, o_power_mgmt_ctrl_stat);
    u_partner.toggle_link();
    cyc(8);
    rd_chk("link change", WAKE_STAT_ADDR, 32'h0000_0080, 32'h0000_0080);
    wr(WAKE_STAT_ADDR, 32'h0000_0000);
    rd_chk("link change kept", WAKE_STAT_ADDR, 32'h0000_0080, 32'h0000_0080);
    wr(WAKE_STAT_ADDR, 32'h0000_0080);
    rd_chk("link change cleared", WAKE_STAT_ADDR, 32'h0000_0080, 32'h0000_0000);
    end_sim();
  end
endmodule
